// [status_srq_unit.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - read-only event register; each standard event latches its own bit
// - event bit holds until the event register read or clear-status
// - enabled event bits are summarised into the ESB bit
// - query values are the binary-weighted sum of the set bits
// - written values weight bit n as two to the n
// - operation-complete set raises OPC once pending work finishes
// - commands keep executing while operation-complete set is pending
// - operation-complete query replies 1 after pending work finishes
// - only device clear executes while the operation-complete query waits
// - status bits ANDed with service enable, ORed into MSS and RQS
// - serial poll clears RQS and leaves MSS alone
// - service enable of zero never raises a service request
// - status byte is read-only, holds summaries and MAV, read keeps it
// - wait command suspends commands until pending work completes
// - device clear or finished pending work ends a wait; other commands are ignored
// - clear-status clears event registers and status, keeps enables
// - a one in an event enable bit reports that event to ESB
module status_srq_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire status_srq_pkg::bus_req_t bus_req,
  output logic [status_srq_pkg::DATA_W-1:0] rdata,
  input wire logic [status_srq_pkg::BYTE_W-1:0] std_event,
  input wire status_srq_pkg::summary_in_t summary_in,
  input wire logic ops_busy,
  output logic srq,
  output logic cmd_stall,
  output logic clear_groups,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [status_srq_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] event_reg;
  logic [7:0] event_en_reg;
  logic [7:0] srq_en_reg;
  logic rqs_reg;
  logic opc_armed_reg;
  logic reply_valid_reg;
  logic [7:0] reply_reg;
  logic [status_srq_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [status_srq_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [status_srq_pkg::DATA_W-1:0] rdata_reg;
  logic srq_reg;
  logic irq_reg;
  logic clear_reg;
  status_srq_pkg::engine_t state_reg;
  status_srq_pkg::engine_t state_next;

  logic wr_cmd;
  status_srq_pkg::cmd_t cmd_code;
  logic cmd_exec;
  logic dev_clear;
  logic clr_status;
  logic rd_event;
  logic rd_poll;
  logic rd_reply;
  logic esb;
  logic mss;
  logic [7:0] status_byte;
  logic ops_done;
  logic opc_fire;
  logic query_fire;
  logic wait_fire;
  logic rqs_rise;
  logic [status_srq_pkg::IRQ_W-1:0] irq_events;
  logic wr_event_en;
  logic wr_srq_en;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wr_cmd = bus_req.wr && hit(bus_req.addr, status_srq_pkg::OFF_CMD);
  assign cmd_code = status_srq_pkg::cmd_t'(bus_req.wdata[$bits(status_srq_pkg::cmd_t)-1:0]);
  // while stalled, only device clear gets through
  assign dev_clear = wr_cmd && (cmd_code == status_srq_pkg::CMD_DEVICE_CLEAR);
  assign cmd_exec = wr_cmd && (state_reg == status_srq_pkg::ST_RUN);
  assign clr_status = cmd_exec && (cmd_code == status_srq_pkg::CMD_CLEAR_STATUS);
  assign rd_event = bus_req.rd && hit(bus_req.addr, status_srq_pkg::OFF_EVENT);
  assign rd_poll = bus_req.rd && hit(bus_req.addr, status_srq_pkg::OFF_POLL);
  assign rd_reply = bus_req.rd && hit(bus_req.addr, status_srq_pkg::OFF_REPLY);
  assign ops_done = !ops_busy;

  // ----------------------------------------------------------------
  // write decode, one strobe per writable register
  // ----------------------------------------------------------------
  always_comb begin
    wr_event_en = 1'b0;
    wr_srq_en = 1'b0;
    wr_irq_stat = 1'b0;
    wr_irq_mask = 1'b0;
    if (bus_req.wr) begin
      if (hit(bus_req.addr, status_srq_pkg::OFF_EVENT_EN)) begin
        wr_event_en = 1'b1;
      end else if (hit(bus_req.addr, status_srq_pkg::OFF_SRQ_EN)) begin
        wr_srq_en = 1'b1;
      end else if (hit(bus_req.addr, status_srq_pkg::OFF_IRQ_STAT)) begin
        wr_irq_stat = 1'b1;
      end else if (hit(bus_req.addr, status_srq_pkg::OFF_IRQ_MASK)) begin
        wr_irq_mask = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // summary bits
  // ----------------------------------------------------------------
  assign esb = |(event_reg & event_en_reg);

  always_comb begin
    status_byte = status_srq_pkg::BYTE_RESET;
    status_byte[status_srq_pkg::ERRQ_BIT] = summary_in.err_queue;
    status_byte[status_srq_pkg::QUES_BIT] = summary_in.ques_sum;
    status_byte[status_srq_pkg::MAV_BIT] = summary_in.mav;
    status_byte[status_srq_pkg::ESB_BIT] = esb;
    status_byte[status_srq_pkg::OPER_BIT] = summary_in.oper_sum;
  end

  // the MSS position itself never feeds back into the sum
  assign mss = |(status_byte & srq_en_reg);

  // ----------------------------------------------------------------
  // standard event register
  // ----------------------------------------------------------------
  assign opc_fire = opc_armed_reg && ops_done;

  // a new event in the cycle of a read or clear still lands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_reg <= status_srq_pkg::BYTE_RESET;
    end else begin
      event_reg <= ((rd_event || clr_status) ? status_srq_pkg::BYTE_RESET : event_reg)
                   | std_event
                   | {{(status_srq_pkg::BYTE_W-1){1'b0}}, opc_fire};
    end
  end

  // ----------------------------------------------------------------
  // enable masks; clear-status leaves them alone
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_en_reg <= status_srq_pkg::BYTE_RESET;
      srq_en_reg <= status_srq_pkg::BYTE_RESET;
    end else if (state_reg == status_srq_pkg::ST_RUN) begin
      // mask writes are commands too, held off while a wait or query pends
      if (wr_event_en) begin
        event_en_reg <= bus_req.wdata[status_srq_pkg::BYTE_W-1:0];
      end else if (wr_srq_en) begin
        srq_en_reg <= bus_req.wdata[status_srq_pkg::BYTE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // operation-complete arming
  // ----------------------------------------------------------------
  // other commands stay accepted while armed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opc_armed_reg <= 1'b0;
    end else if (dev_clear) begin
      opc_armed_reg <= 1'b0;
    end else if (cmd_exec && (cmd_code == status_srq_pkg::CMD_OPC_SET)) begin
      opc_armed_reg <= 1'b1;
    end else if (opc_fire) begin
      opc_armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      status_srq_pkg::ST_RUN: begin
        if (cmd_exec && (cmd_code == status_srq_pkg::CMD_WAIT)) begin
          state_next = status_srq_pkg::ST_WAIT_OPS;
        end else if (cmd_exec && (cmd_code == status_srq_pkg::CMD_OPC_QUERY)) begin
          state_next = status_srq_pkg::ST_QUERY_OPS;
        end
      end
      status_srq_pkg::ST_WAIT_OPS: begin
        if (dev_clear || ops_done) begin
          state_next = status_srq_pkg::ST_RUN;
        end
      end
      status_srq_pkg::ST_QUERY_OPS: begin
        if (dev_clear || ops_done) begin
          state_next = status_srq_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = status_srq_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= status_srq_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // a device clear in the finishing cycle wins: no reply and no wait-done flag
  assign query_fire = (state_reg == status_srq_pkg::ST_QUERY_OPS) && ops_done && !dev_clear;
  assign wait_fire = (state_reg == status_srq_pkg::ST_WAIT_OPS) && ops_done && !dev_clear;

  // stall mirrors the next state so it rises with the accepting edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_stall <= 1'b0;
    end else begin
      cmd_stall <= (state_next != status_srq_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // output buffer for the operation-complete reply
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reply_valid_reg <= 1'b0;
      reply_reg <= status_srq_pkg::BYTE_RESET;
    end else if (query_fire) begin
      reply_valid_reg <= 1'b1;
      reply_reg <= status_srq_pkg::REPLY_ONE;
    end else if (rd_reply || dev_clear) begin
      reply_valid_reg <= 1'b0;
      reply_reg <= status_srq_pkg::BYTE_RESET;
    end
  end

  // ----------------------------------------------------------------
  // request for service
  // ----------------------------------------------------------------
  // RQS latches on a rising MSS; a steady MSS after a poll does not re-raise it
  logic mss_prev_reg;
  assign rqs_rise = mss && !mss_prev_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mss_prev_reg <= 1'b0;
    end else begin
      mss_prev_reg <= mss;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rqs_reg <= 1'b0;
    end else if (rqs_rise) begin
      rqs_reg <= 1'b1;
    end else if (rd_poll || clr_status || !mss) begin
      rqs_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srq_reg <= 1'b0;
    end else begin
      srq_reg <= rqs_rise || (rqs_reg && mss && !rd_poll && !clr_status);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= clr_status;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    irq_events = status_srq_pkg::IRQ_RESET;
    irq_events[status_srq_pkg::IRQ_OPC] = opc_fire;
    irq_events[status_srq_pkg::IRQ_REPLY] = query_fire;
    irq_events[status_srq_pkg::IRQ_SRQ] = rqs_rise;
    irq_events[status_srq_pkg::IRQ_WAIT] = wait_fire;
  end

  // write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= status_srq_pkg::IRQ_RESET;
    end else if (wr_irq_stat) begin
      irq_stat_reg <= (irq_stat_reg & ~bus_req.wdata[status_srq_pkg::IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_events;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= status_srq_pkg::IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= bus_req.wdata[status_srq_pkg::IRQ_W-1:0];
    end
  end

  // follows the status register one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe and only then
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= status_srq_pkg::WORD_ZERO;
    end else begin
      rdata_reg <= status_srq_pkg::WORD_ZERO;
      if (bus_req.rd) begin
        // plain binary is the binary-weighted sum software sees
        if (hit(bus_req.addr, status_srq_pkg::OFF_EVENT)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= event_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_EVENT_EN)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= event_en_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_SRQ_EN)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= srq_en_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_STATUS)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= status_byte;
          rdata_reg[status_srq_pkg::MSS_BIT] <= mss;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_POLL)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= status_byte;
          rdata_reg[status_srq_pkg::MSS_BIT] <= rqs_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_REPLY)) begin
          rdata_reg[status_srq_pkg::BYTE_W-1:0] <= reply_reg;
          rdata_reg[status_srq_pkg::REPLY_VALID_BIT] <= reply_valid_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_IRQ_STAT)) begin
          rdata_reg[status_srq_pkg::IRQ_W-1:0] <= irq_stat_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_IRQ_MASK)) begin
          rdata_reg[status_srq_pkg::IRQ_W-1:0] <= irq_mask_reg;
        end else if (hit(bus_req.addr, status_srq_pkg::OFF_ENGINE)) begin
          // state code with the arming flag just above it, for software debug
          rdata_reg[$bits(status_srq_pkg::engine_t)-1:0] <= state_reg;
          rdata_reg[$bits(status_srq_pkg::engine_t)] <= opc_armed_reg;
        end
      end
    end
  end

  assign rdata = rdata_reg;
  assign srq = srq_reg;
  assign clear_groups = clear_reg;
  assign irq = irq_reg;

endmodule

`default_nettype wire

// [status_srq_pkg.sv]
package status_srq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_EVENT = 8'h00;
  localparam logic [7:0] OFF_EVENT_EN = 8'h04;
  localparam logic [7:0] OFF_SRQ_EN = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_REPLY = 8'h14;
  localparam logic [7:0] OFF_POLL = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_ENGINE = 8'h24;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int OPC_BIT = 0;
  localparam int ERRQ_BIT = 2;
  localparam int QUES_BIT = 3;
  localparam int MAV_BIT = 4;
  localparam int ESB_BIT = 5;
  localparam int MSS_BIT = 6;
  localparam int OPER_BIT = 7;
  localparam int REPLY_VALID_BIT = 8;
  localparam logic [7:0] REPLY_ONE = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  localparam int IRQ_W = 4;
  localparam int IRQ_OPC = 0;
  localparam int IRQ_REPLY = 1;
  localparam int IRQ_SRQ = 2;
  localparam int IRQ_WAIT = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ----------------------------------------------------------------
  // commands and engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_OPC_SET = 3'b001,
    CMD_OPC_QUERY = 3'b010,
    CMD_WAIT = 3'b011,
    CMD_CLEAR_STATUS = 3'b100,
    CMD_DEVICE_CLEAR = 3'b101
  } cmd_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT_OPS = 2'b01,
    ST_QUERY_OPS = 2'b10
  } engine_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic oper_sum;
    logic ques_sum;
    logic err_queue;
    logic mav;
  } summary_in_t;

endpackage

// [status_srq_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module status_srq_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire status_srq_pkg::bus_req_t bus_req,
  input wire logic [status_srq_pkg::DATA_W-1:0] rdata,
  input wire logic [status_srq_pkg::BYTE_W-1:0] std_event,
  input wire status_srq_pkg::summary_in_t summary_in,
  input wire logic ops_busy,
  input wire logic srq,
  input wire logic cmd_stall,
  input wire logic clear_groups,
  input wire logic irq
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cmd_wr;
  logic [2:0] op;
  assign cmd_wr = bus_req.wr && (bus_req.addr == status_srq_pkg::OFF_CMD);
  assign op = bus_req.wdata[2:0];

  property p_rdata_idle;
    !$past(bus_req.rd) |-> rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero outside read");
  property p_query_stall;
    cmd_wr && op == 3'h2 && !cmd_stall && ops_busy |=> cmd_stall;
  endproperty
  a_query_stall: assert property (p_query_stall) else $error("query did not stall");
  property p_wait_stall;
    cmd_wr && op == 3'h3 && !cmd_stall && ops_busy |=> cmd_stall;
  endproperty
  a_wait_stall: assert property (p_wait_stall) else $error("wait did not stall");
  property p_stall_end;
    cmd_stall && !ops_busy |=> !cmd_stall;
  endproperty
  a_stall_end: assert property (p_stall_end) else $error("stall outlived pending work");
  property p_stall_hold;
    cmd_stall && ops_busy && !(cmd_wr && op == 3'h5) |=> cmd_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall ended early");
  property p_stall_ignores;
    cmd_stall && cmd_wr && op == 3'h4 |=> !clear_groups;
  endproperty
  a_stall_ignores: assert property (p_stall_ignores) else $error("command ran in stall");
  property p_clear_pulse;
    cmd_wr && op == 3'h4 && !cmd_stall |=> clear_groups ##1 !clear_groups;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong");
  property p_opc_no_stall;
    cmd_wr && op == 3'h1 && !cmd_stall |=> !cmd_stall;
  endproperty
  a_opc_no_stall: assert property (p_opc_no_stall) else $error("opc set stalled");
  property p_status_keep;
    bus_req.rd && bus_req.addr == status_srq_pkg::OFF_STATUS |=>
      rdata[status_srq_pkg::MAV_BIT] == $past(summary_in.mav) && rdata[31:8] == '0;
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("status read wrong");
  property p_poll_clears;
    bus_req.rd && bus_req.addr == status_srq_pkg::OFF_POLL && srq |-> ##2 !srq;
  endproperty
  a_poll_clears: assert property (p_poll_clears) else $error("poll left srq up");
endmodule

`default_nettype wire

// [controller_model.sv]
`timescale 1ns/1ps
`default_nettype none

module controller_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output var status_srq_pkg::bus_req_t bus_req
);
  // ----------------------------------------
  // register access as the remote controller
  // ----------------------------------------
  initial bus_req = '0;
  // values are binary weighted, bit n worth two to the n
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'h0, rd: 1'h0};
    #1;
    v = rdata;
  endtask
endmodule

`default_nettype wire

// [status_srq_unit_test.sv]
`timescale 1ns/1ps
`default_nettype none

module status_srq_unit_test;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  localparam logic [7:0] A_EV = status_srq_pkg::OFF_EVENT;
  localparam logic [7:0] A_ST = status_srq_pkg::OFF_STATUS;
  localparam logic [7:0] A_CMD = status_srq_pkg::OFF_CMD;
  localparam logic [7:0] A_PL = status_srq_pkg::OFF_POLL;
  localparam logic [7:0] A_IS = status_srq_pkg::OFF_IRQ_STAT;
  logic clk;
  logic sys_rst;
  status_srq_pkg::bus_req_t bus_req;
  logic [31:0] rdata;
  logic [7:0] std_event;
  status_srq_pkg::summary_in_t summary_in;
  logic ops_busy, srq, cmd_stall, clear_groups, irq;
  int mismatches = 0;
  int total_checks = 0;

  status_srq_unit u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
    .std_event(std_event), .summary_in(summary_in), .ops_busy(ops_busy), .srq(srq),
    .cmd_stall(cmd_stall), .clear_groups(clear_groups), .irq(irq));
  controller_model u_host (.clk(clk), .rdata(rdata), .bus_req(bus_req));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    u_host.rd(a, v);
    check($sformatf("reg_%0h", a), v, e);
  endtask
  task automatic fc(input string what, input logic f, input logic e);
    check(what, {31'h0, f}, {31'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic [7:0] e);
    @(posedge clk);
    std_event <= e;
    @(posedge clk);
    std_event <= 8'h00;
  endtask
  task automatic busy(input logic b);
    @(posedge clk);
    ops_busy <= b;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    sys_rst = 1'h1;
    std_event = 8'h00;
    summary_in = '0;
    ops_busy = 1'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    rc(A_EV, 32'h0);
    rc(A_ST, 32'h0);
    u_host.wr(8'h30, 32'h5A);
    rc(8'h30, 32'h0);
    u_host.wr(status_srq_pkg::OFF_SRQ_EN, 32'h18);
    rc(status_srq_pkg::OFF_SRQ_EN, 32'h18);
    ev(8'hA4);
    rc(A_EV, 32'hA4);
    rc(A_EV, 32'h0);
    ev(8'h08);
    rc(A_ST, 32'h0);
    u_host.wr(status_srq_pkg::OFF_EVENT_EN, 32'h08);
    rc(A_ST, 32'h20);
    u_host.wr(status_srq_pkg::OFF_SRQ_EN, 32'h20);
    rc(A_ST, 32'h60);
    wt(3);
    fc("srq", srq, 1'h1);
    rc(A_PL, 32'h60);
    wt(2);
    fc("srq", srq, 1'h0);
    rc(A_ST, 32'h60);
    rc(A_PL, 32'h20);
    u_host.wr(status_srq_pkg::OFF_SRQ_EN, 32'h0);
    ev(8'hFF);
    wt(4);
    fc("srq", srq, 1'h0);
    u_host.wr(A_CMD, 32'h4);
    wt(0);
    fc("clear_groups", clear_groups, 1'h1);
    wt(1);
    fc("clear_groups", clear_groups, 1'h0);
    rc(A_EV, 32'h0);
    rc(status_srq_pkg::OFF_EVENT_EN, 32'h08);
    ev(8'h02);
    busy(1'h1);
    u_host.wr(A_CMD, 32'h2);
    wt(0);
    fc("cmd_stall", cmd_stall, 1'h1);
    u_host.wr(A_CMD, 32'h4);
    wt(0);
    fc("clear_groups", clear_groups, 1'h0);
    u_host.wr(status_srq_pkg::OFF_SRQ_EN, 32'h18);
    rc(status_srq_pkg::OFF_SRQ_EN, 32'h0);
    rc(status_srq_pkg::OFF_REPLY, 32'h0);
    busy(1'h0);
    wt(3);
    fc("cmd_stall", cmd_stall, 1'h0);
    rc(status_srq_pkg::OFF_REPLY, 32'h101);
    rc(status_srq_pkg::OFF_REPLY, 32'h0);
    rc(A_EV, 32'h02);
    busy(1'h1);
    u_host.wr(A_CMD, 32'h3);
    u_host.wr(A_CMD, 32'h1);
    wt(2);
    fc("cmd_stall", cmd_stall, 1'h1);
    rc(status_srq_pkg::OFF_ENGINE, 32'h1);
    // with work still pending, only device clear may end the wait
    u_host.wr(A_CMD, 32'h5);
    wt(1);
    fc("cmd_stall", cmd_stall, 1'h0);
    busy(1'h1);
    u_host.wr(A_CMD, 32'h3);
    wt(0);
    fc("cmd_stall", cmd_stall, 1'h1);
    busy(1'h0);
    wt(2);
    fc("cmd_stall", cmd_stall, 1'h0);
    rc(A_IS, 32'hE);
    busy(1'h1);
    u_host.wr(A_IS, 32'hF);
    u_host.wr(A_CMD, 32'h1);
    wt(0);
    fc("cmd_stall", cmd_stall, 1'h0);
    rc(status_srq_pkg::OFF_ENGINE, 32'h4);
    rc(A_EV, 32'h0);
    busy(1'h0);
    wt(3);
    rc(A_EV, 32'h01);
    rc(A_IS, 32'h1);
    fc("irq", irq, 1'h0);
    u_host.wr(status_srq_pkg::OFF_IRQ_MASK, 32'h1);
    wt(2);
    fc("irq", irq, 1'h1);
    u_host.wr(A_IS, 32'h1);
    wt(2);
    fc("irq", irq, 1'h0);
    @(posedge clk);
    summary_in <= '{oper_sum: 1'h1, ques_sum: 1'h0, err_queue: 1'h1, mav: 1'h1};
    rc(A_ST, 32'h94);
    rc(A_ST, 32'h94);
    summarize();
  end

  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule

bind status_srq_unit status_srq_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .rdata(rdata), .std_event(std_event), .summary_in(summary_in),
  .ops_busy(ops_busy), .srq(srq), .cmd_stall(cmd_stall), .clear_groups(clear_groups),
  .irq(irq));

`default_nettype wire
